// *** core/epm_device.sv ***
// Pin function mux for the encoder, timer and serial pins
// Function
// R1: Full variant index pin defaults to index
// R2: Full variant home pin defaults to home
// R3: Full variant pulse pin defaults to pulse
// R4: Reduced variant pins reset to no function
// R5: Serial clock pin defaults to serial clock
// R6: Master-out pin defaults to serial data
// R7: Each port bit has own direction
// R8: Master drives serial clock pin out
// R9: Slave takes clock from external master
// R10: Master data leads slave sample half-cycle
// R11: Slave data leads master sample half-cycle
// R12: Unselected slave releases master-in line
// R13: External master asserts select for slave
// R14: Master-in pin offers async receive alternate
// R15: Select pin offers async transmit alternate
// R16: Index pin can show system clock
// R17: Home pin can show prescaler clock
// R18: Index and home offer timer channels
// R19: Test out driven in shift, falling edge
// R20: In reset drivers off, pull-ups on
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "epm_regs.svh"
`default_nettype none
module epm_device #(
  parameter bit FULL_VARIANT = 1'b1,
  parameter int HALF_CYC     = `EPM_HALF_CYC
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  epm_if.dev                     pins,
  input  wire epm_pkg::epm_addr_t addr,
  input  wire epm_pkg::epm_data_t wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output var epm_pkg::epm_data_t rdata,
  output logic                   qdec_index_input,
  output logic                   qdec_home_input,
  input  wire logic              timer_two_o,
  input  wire logic              timer_two_oe,
  output logic                   timer_two_i,
  input  wire logic              timer_three_o,
  input  wire logic              timer_three_oe,
  output logic                   timer_three_i,
  input  wire logic              system_clock_monitor,
  input  wire logic              prescaler_clock_monitor,
  input  wire logic              pulse_output_zero,
  input  wire logic              async1_transmit_output,
  output logic                   async1_receive_input,
  input  wire logic              test_clock,
  input  wire logic              test_shift,
  input  wire logic              test_data
);
  import epm_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
  // Port-bit code of each pin slot
  localparam epm_fsel_t SEL_GPIO [0:6] = '{`EPM_F_ALT2, `EPM_F_ALT2, `EPM_F_ALT1,
                                           `EPM_F_ALT1, `EPM_F_ALT2, `EPM_F_ALT2,
                                           `EPM_F_ALT1};

  if (HALF_CYC < 6 || HALF_CYC > 255) begin : g_bad_half
    $error("HALF_CYC must lie in 6..255");
  end

  epm_pins_t   meta_reg;
  epm_pins_t   sync_reg;
  logic        live_reg;
  epm_fsel_t   sel_reg [0:6];
  epm_pins_t   dir_reg;
  epm_pins_t   out_reg;
  logic        master_reg;
  logic        en_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_data_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  div_reg;
  logic        sclk_out_reg;
  logic        sclk_prev_reg;
  logic        done_reg;
  epm_spi_st_t st_reg;
  logic        tck_meta_reg;
  logic        tck_sync_reg;
  logic        tck_prev_reg;
  logic        tdo_reg;
  epm_pins_t   pin_o;
  epm_pins_t   pin_oe;
  logic        master_on;
  logic        slave_sel;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        tx_wr;
  logic        xfer_done;

  assign master_on = en_reg & master_reg & sel_reg[`EPM_PIN_SCLK] == `EPM_F_PRIMARY;
  // R13 slave mode answers only while select is low
  assign slave_sel = en_reg & ~master_reg & sel_reg[`EPM_PIN_SS] == `EPM_F_PRIMARY
                   & sel_reg[`EPM_PIN_SCLK] == `EPM_F_PRIMARY & ~sync_reg[`EPM_PIN_SS];
  assign sclk_rise = sync_reg[`EPM_PIN_SCLK] & ~sclk_prev_reg;
  assign sclk_fall = ~sync_reg[`EPM_PIN_SCLK] & sclk_prev_reg;
  assign tx_wr     = wr_stb && addr == `EPM_SPI_TX;
  assign xfer_done = (st_reg == EPM_HIGH && div_reg == HALF_LAST && bit_reg == 3'h7)
                   | (slave_sel && sclk_rise && bit_reg == 3'h7);

  // Pins and test clock cross two flops before use
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg      <= 7'h7F;
      sync_reg      <= 7'h7F;
      // Matches the pulled-up clock, so no false edge after reset
      sclk_prev_reg <= 1'b1;
      tck_meta_reg  <= 1'b0;
      tck_sync_reg  <= 1'b0;
      tck_prev_reg  <= 1'b0;
    end else begin
      meta_reg      <= pins.pin;
      sync_reg      <= meta_reg;
      sclk_prev_reg <= sync_reg[`EPM_PIN_SCLK];
      tck_meta_reg  <= test_clock;
      tck_sync_reg  <= tck_meta_reg;
      tck_prev_reg  <= tck_sync_reg;
    end
  end

  // R20 drivers held off until the first edge after release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 7; i++) begin
        // R1 R2 R3 R4 variant decides the default
        if (!FULL_VARIANT && (i == `EPM_PIN_IDX || i == `EPM_PIN_HOME
                              || i == `EPM_PIN_PWM)) begin
          sel_reg[i] <= `EPM_F_NONE;
        end else begin
          // R5 R6 R14 R15 serial functions first
          sel_reg[i] <= `EPM_F_PRIMARY;
        end
      end
      dir_reg    <= `EPM_DIR_RST;
      out_reg    <= `EPM_OUT_RST;
      master_reg <= 1'b0;
      en_reg     <= 1'b0;
    end else if (wr_stb) begin
      if (addr < `EPM_DIR) begin
        sel_reg[addr[2:0]] <= wdata[2:0];
      end
      if (addr == `EPM_DIR) begin
        dir_reg <= wdata[6:0];
      end
      if (addr == `EPM_OUT) begin
        out_reg <= wdata[6:0];
      end
      if (addr == `EPM_SPI_CTRL) begin
        master_reg <= wdata[`EPM_CTRL_MASTER];
        en_reg     <= wdata[`EPM_CTRL_EN];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg       <= EPM_IDLE;
      tx_reg       <= 8'h00;
      rx_reg       <= 8'h00;
      bit_reg      <= 3'h0;
      div_reg      <= 8'h00;
      sclk_out_reg <= 1'b0;
    end else begin
      case (st_reg)
        EPM_IDLE: begin
          div_reg      <= 8'h00;
          sclk_out_reg <= 1'b0;
          if (!slave_sel) begin
            bit_reg <= 3'h0;
          end else if (sclk_rise) begin
            // R9 slave shifts on the external clock
            rx_reg  <= {rx_reg[6:0], sync_reg[`EPM_PIN_MOSI]};
            bit_reg <= bit_reg + 3'h1;
          end else if (sclk_fall) begin
            // R11 next bit presented on the fall
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
          // Late write wins; preloads slave data too
          if (tx_wr) begin
            tx_reg <= wdata[7:0];
          end
          if (tx_wr && master_on) begin
            bit_reg <= 3'h0;
            st_reg  <= EPM_LOW;
          end
        end
        EPM_LOW: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == HALF_LAST) begin
            div_reg      <= 8'h00;
            sclk_out_reg <= 1'b1;
            rx_reg       <= {rx_reg[6:0], sync_reg[`EPM_PIN_MISO]};
            st_reg       <= EPM_HIGH;
          end
        end
        EPM_HIGH: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == HALF_LAST) begin
            div_reg      <= 8'h00;
            sclk_out_reg <= 1'b0;
            if (bit_reg == 3'h7) begin
              st_reg <= EPM_IDLE;
            end else begin
              // R10 data moves a half period before the rise
              bit_reg <= bit_reg + 3'h1;
              tx_reg  <= {tx_reg[6:0], 1'b0};
              st_reg  <= EPM_LOW;
            end
          end
        end
        default: st_reg <= EPM_IDLE;
      endcase
    end
  end

  // Done flag: a completing transfer beats a clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_reg <= 8'h00;
      done_reg    <= 1'b0;
    end else begin
      if (xfer_done) begin
        rx_data_reg <= master_on ? rx_reg : {rx_reg[6:0], sync_reg[`EPM_PIN_MOSI]};
        done_reg    <= 1'b1;
      end else if (wr_stb && addr == `EPM_SPI_STAT && wdata[`EPM_STAT_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // R19 test out moves on the test clock fall
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tdo_reg <= 1'b1;
    end else if (tck_prev_reg && !tck_sync_reg) begin
      tdo_reg <= test_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= 16'h0000;
      if (rd_stb) begin
        if (addr < `EPM_DIR) begin
          rdata <= {13'h0000, sel_reg[addr[2:0]]};
        end else begin
          case (addr)
            `EPM_DIR:      rdata <= {9'h000, dir_reg};
            `EPM_OUT:      rdata <= {9'h000, out_reg};
            `EPM_IN:       rdata <= {9'h000, sync_reg};
            `EPM_SPI_CTRL: rdata <= {14'h0000, en_reg, master_reg};
            `EPM_SPI_TX:   rdata <= {8'h00, tx_reg};
            `EPM_SPI_RX:   rdata <= {8'h00, rx_data_reg};
            `EPM_SPI_STAT: rdata <= {14'h0000, done_reg,
                                     st_reg != EPM_IDLE || (slave_sel && bit_reg != 3'h0)};
            default:       rdata <= 16'h0000;
          endcase
        end
      end
    end
  end

  always_comb begin
    pin_o  = 7'h00;
    pin_oe = 7'h00;
    for (int i = 0; i < 7; i++) begin
      // R7 per-pin direction in port role
      if (sel_reg[i] == SEL_GPIO[i]) begin
        pin_o[i]  = out_reg[i];
        pin_oe[i] = dir_reg[i];
      end
    end
    // R18 timer channels are two-way
    if (sel_reg[`EPM_PIN_IDX] == `EPM_F_ALT1) begin
      pin_o[`EPM_PIN_IDX]  = timer_two_o;
      pin_oe[`EPM_PIN_IDX] = timer_two_oe;
    end
    // R16 system clock shown on index pin
    if (sel_reg[`EPM_PIN_IDX] == `EPM_F_ALT3) begin
      pin_o[`EPM_PIN_IDX]  = system_clock_monitor;
      pin_oe[`EPM_PIN_IDX] = 1'b1;
    end
    if (sel_reg[`EPM_PIN_HOME] == `EPM_F_ALT1) begin
      pin_o[`EPM_PIN_HOME]  = timer_three_o;
      pin_oe[`EPM_PIN_HOME] = timer_three_oe;
    end
    // R17 prescaler clock shown on home pin
    if (sel_reg[`EPM_PIN_HOME] == `EPM_F_ALT3) begin
      pin_o[`EPM_PIN_HOME]  = prescaler_clock_monitor;
      pin_oe[`EPM_PIN_HOME] = 1'b1;
    end
    // R8 master drives the serial clock
    if (master_on) begin
      pin_o[`EPM_PIN_SCLK]  = sclk_out_reg;
      pin_oe[`EPM_PIN_SCLK] = 1'b1;
    end
    if (master_on && sel_reg[`EPM_PIN_MOSI] == `EPM_F_PRIMARY) begin
      pin_o[`EPM_PIN_MOSI]  = tx_reg[7];
      pin_oe[`EPM_PIN_MOSI] = 1'b1;
    end
    // R12 slave drives only while selected
    if (slave_sel && sel_reg[`EPM_PIN_MISO] == `EPM_F_PRIMARY) begin
      pin_o[`EPM_PIN_MISO]  = tx_reg[7];
      pin_oe[`EPM_PIN_MISO] = 1'b1;
    end
    // R15 async transmit on select pin
    if (sel_reg[`EPM_PIN_SS] == `EPM_F_ALT1) begin
      pin_o[`EPM_PIN_SS]  = async1_transmit_output;
      pin_oe[`EPM_PIN_SS] = 1'b1;
    end
    if (sel_reg[`EPM_PIN_PWM] == `EPM_F_PRIMARY) begin
      pin_o[`EPM_PIN_PWM]  = pulse_output_zero;
      pin_oe[`EPM_PIN_PWM] = 1'b1;
    end
  end

  // R20 enables gated, pull-up on whenever not driving
  assign pins.dev_o       = pin_o;
  assign pins.dev_oe      = pin_oe & {7{live_reg}};
  assign pins.dev_pu      = ~(pin_oe & {7{live_reg}});
  assign pins.test_out_o  = tdo_reg;
  assign pins.test_out_oe = test_shift & live_reg;

  // Function inputs read only the synchronised pins
  assign qdec_index_input = sel_reg[`EPM_PIN_IDX] == `EPM_F_PRIMARY & sync_reg[`EPM_PIN_IDX];
  assign qdec_home_input  = sel_reg[`EPM_PIN_HOME] == `EPM_F_PRIMARY & sync_reg[`EPM_PIN_HOME];
  assign timer_two_i      = sel_reg[`EPM_PIN_IDX] == `EPM_F_ALT1 & sync_reg[`EPM_PIN_IDX];
  assign timer_three_i    = sel_reg[`EPM_PIN_HOME] == `EPM_F_ALT1 & sync_reg[`EPM_PIN_HOME];
  // R14 async receive idles high when not selected
  assign async1_receive_input = sel_reg[`EPM_PIN_MISO] != `EPM_F_ALT1
                              | sync_reg[`EPM_PIN_MISO];
endmodule : epm_device
`default_nettype wire

// *** core/epm_far.sv ***
// External serial master or slave that faces the shared pins
`include "epm_regs.svh"
`default_nettype none
module epm_far #(
  parameter int HALF_CYC = `EPM_HALF_CYC
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  epm_if.far                     pins,
  input  wire epm_pkg::epm_addr_t addr,
  input  wire epm_pkg::epm_data_t wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output var epm_pkg::epm_data_t rdata
);
  import epm_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  if (HALF_CYC < 6 || HALF_CYC > 255) begin : g_bad_half
    $error("HALF_CYC must lie in 6..255");
  end

  logic [3:0]  meta_reg;
  logic [3:0]  sync_reg;
  logic        sclk_prev_reg;
  logic        master_reg;
  logic        en_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_data_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  div_reg;
  logic        sclk_out_reg;
  logic        done_reg;
  epm_spi_st_t st_reg;
  logic        master_on;
  logic        selected;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        tx_wr;
  logic        xfer_done;

  assign master_on = en_reg & master_reg;
  // R13 slave listens only while select is low
  assign selected  = en_reg & ~master_reg & ~sync_reg[3];
  assign sclk_rise = sync_reg[0] & ~sclk_prev_reg;
  assign sclk_fall = ~sync_reg[0] & sclk_prev_reg;
  assign tx_wr     = wr_stb && addr == `EPM_FAR_TX;
  assign xfer_done = (st_reg == EPM_HIGH && div_reg == HALF_LAST && bit_reg == 3'h7)
                   | (selected && sclk_rise && bit_reg == 3'h7);

  // Pin inputs cross two flops before use
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg      <= 4'hF;
      sync_reg      <= 4'hF;
      // Matches the pulled-up clock, so no false edge after reset
      sclk_prev_reg <= 1'b1;
    end else begin
      meta_reg      <= pins.pin[5:2];
      sync_reg      <= meta_reg;
      sclk_prev_reg <= sync_reg[0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      master_reg <= 1'b0;
      en_reg     <= 1'b0;
    end else if (wr_stb && addr == `EPM_FAR_CTRL) begin
      master_reg <= wdata[`EPM_CTRL_MASTER];
      en_reg     <= wdata[`EPM_CTRL_EN];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg       <= EPM_IDLE;
      tx_reg       <= 8'h00;
      rx_reg       <= 8'h00;
      bit_reg      <= 3'h0;
      div_reg      <= 8'h00;
      sclk_out_reg <= 1'b0;
    end else begin
      case (st_reg)
        EPM_IDLE: begin
          div_reg      <= 8'h00;
          sclk_out_reg <= 1'b0;
          if (!selected) begin
            bit_reg <= 3'h0;
          end else if (sclk_rise) begin
            // R10 slave samples data on the rising edge
            rx_reg  <= {rx_reg[6:0], sync_reg[1]};
            bit_reg <= bit_reg + 3'h1;
          end else if (sclk_fall) begin
            // R11 next bit out half a cycle early
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
          if (tx_wr) begin
            tx_reg <= wdata[7:0];
          end
          if (tx_wr && master_on) begin
            bit_reg <= 3'h0;
            st_reg  <= EPM_LOW;
          end
        end
        EPM_LOW: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == HALF_LAST) begin
            div_reg      <= 8'h00;
            sclk_out_reg <= 1'b1;
            // R11 master samples slave data on the rise
            rx_reg       <= {rx_reg[6:0], sync_reg[2]};
            st_reg       <= EPM_HIGH;
          end
        end
        EPM_HIGH: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == HALF_LAST) begin
            div_reg      <= 8'h00;
            sclk_out_reg <= 1'b0;
            if (bit_reg == 3'h7) begin
              st_reg <= EPM_IDLE;
            end else begin
              bit_reg <= bit_reg + 3'h1;
              tx_reg  <= {tx_reg[6:0], 1'b0};
              st_reg  <= EPM_LOW;
            end
          end
        end
        default: st_reg <= EPM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_reg <= 8'h00;
      done_reg    <= 1'b0;
    end else begin
      if (xfer_done) begin
        rx_data_reg <= master_on ? rx_reg : {rx_reg[6:0], sync_reg[1]};
        done_reg    <= 1'b1;
      end else if (wr_stb && addr == `EPM_FAR_STAT && wdata[`EPM_STAT_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= 16'h0000;
      if (rd_stb) begin
        case (addr)
          `EPM_FAR_CTRL: rdata <= {14'h0000, en_reg, master_reg};
          `EPM_FAR_TX:   rdata <= {8'h00, tx_reg};
          `EPM_FAR_RX:   rdata <= {8'h00, rx_data_reg};
          `EPM_FAR_STAT: rdata <= {14'h0000, done_reg, st_reg != EPM_IDLE};
          default:       rdata <= 16'h0000;
        endcase
      end
    end
  end

  // R9 external master supplies the clock
  always_comb begin
    pins.far_o  = 7'h00;
    pins.far_oe = 7'h00;
    pins.far_o[`EPM_PIN_SCLK]  = sclk_out_reg;
    pins.far_oe[`EPM_PIN_SCLK] = master_on;
    pins.far_o[`EPM_PIN_MOSI]  = tx_reg[7];
    pins.far_oe[`EPM_PIN_MOSI] = master_on;
    // R13 select held low across the frame
    pins.far_o[`EPM_PIN_SS]    = st_reg == EPM_IDLE;
    pins.far_oe[`EPM_PIN_SS]   = master_on;
    // R12 data line released when not selected
    pins.far_o[`EPM_PIN_MISO]  = tx_reg[7];
    pins.far_oe[`EPM_PIN_MISO] = selected;
  end
endmodule : epm_far
`default_nettype wire

// *** core/epm_if.sv ***
// Shared pin wires between the pin mux and the external serial party
`default_nettype none
interface epm_if;
  import epm_pkg::*;
  epm_pins_t dev_o;
  epm_pins_t dev_oe;
  epm_pins_t dev_pu;
  epm_pins_t far_o;
  epm_pins_t far_oe;
  epm_pins_t ext_o;
  epm_pins_t ext_oe;
  epm_pins_t pin;
  logic      test_out_o;
  logic      test_out_oe;

  // Undriven pin floats high on the pull-up
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (dev_oe[i]) begin
        pin[i] = dev_o[i];
      end else if (far_oe[i]) begin
        pin[i] = far_o[i];
      end else if (ext_oe[i]) begin
        pin[i] = ext_o[i];
      end else begin
        pin[i] = 1'b1;
      end
    end
  end

  modport dev (output dev_o, dev_oe, dev_pu, test_out_o, test_out_oe, input pin);
  modport far (output far_o, far_oe, input pin);
endinterface : epm_if
`default_nettype wire

// *** core/epm_pkg.sv ***
// Types shared by the pin mux and its far end
`default_nettype none
package epm_pkg;
  typedef logic [3:0] epm_addr_t;
  typedef logic [15:0] epm_data_t;
  typedef logic [2:0] epm_fsel_t;
  typedef logic [6:0] epm_pins_t;
  typedef enum logic [1:0] {
    EPM_IDLE = 2'b00,
    EPM_LOW  = 2'b01,
    EPM_HIGH = 2'b11
  } epm_spi_st_t;
endpackage : epm_pkg
`default_nettype wire

// *** core/epm_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef EPM_REGS_SVH
`define EPM_REGS_SVH
// Pin slots in every pin vector
`define EPM_PIN_IDX 0
`define EPM_PIN_HOME 1
`define EPM_PIN_SCLK 2
`define EPM_PIN_MOSI 3
`define EPM_PIN_MISO 4
`define EPM_PIN_SS 5
`define EPM_PIN_PWM 6
// Device register map (word index), selectors at base plus pin slot
`define EPM_FSEL_BASE 4'h0
`define EPM_DIR 4'h7
`define EPM_OUT 4'h8
`define EPM_IN 4'h9
`define EPM_SPI_CTRL 4'hA
`define EPM_SPI_TX 4'hB
`define EPM_SPI_RX 4'hC
`define EPM_SPI_STAT 4'hD
// Far end register map
`define EPM_FAR_CTRL 4'h0
`define EPM_FAR_TX 4'h1
`define EPM_FAR_RX 4'h2
`define EPM_FAR_STAT 4'h3
// Field positions
`define EPM_CTRL_MASTER 0
`define EPM_CTRL_EN 1
`define EPM_STAT_BUSY 0
`define EPM_STAT_DONE 1
// Function codes
`define EPM_F_PRIMARY 3'h0
`define EPM_F_ALT1 3'h1
`define EPM_F_ALT2 3'h2
`define EPM_F_ALT3 3'h3
`define EPM_F_NONE 3'h7
// Reset values
`define EPM_DIR_RST 7'h00
`define EPM_OUT_RST 7'h00
// Serial clock half period in clock cycles; round trip through both synchronisers needs six
`define EPM_HALF_CYC 8
`endif

// *** testbench/epm_sva.sv ***
// Assertions on the shared pin wires
`default_nettype none
module epm_sva (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire epm_pkg::epm_pins_t dev_oe,
  input wire epm_pkg::epm_pins_t dev_pu,
  input wire epm_pkg::epm_pins_t far_oe,
  input wire epm_pkg::epm_pins_t pin,
  input wire logic               test_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import epm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Must hold inside reset, so no disable here
  property p_rst_off;
    disable iff (1'b0) !reset_n |-> dev_oe == 7'h00 && dev_pu == 7'h7F
      && !test_out_oe && far_oe == 7'h00;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("driver on in reset");
  property p_pull;
    dev_pu == ~dev_oe;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up not opposite enable");
  property p_live;
    $rose(reset_n) |-> dev_oe == 7'h00;
  endproperty
  a_live: assert property (p_live) else $error("driver on at release");
  property p_sclk_hi;
    $rose(pin[2]) && dev_oe[2] |-> (pin[2] && dev_oe[2]) [*8];
  endproperty
  a_sclk_hi: assert property (p_sclk_hi) else $error("clock high phase short");
  // Data must have settled three cycles before the rising clock
  property p_mosi_lead;
    $rose(pin[2]) && dev_oe[2] |-> pin[3] == $past(pin[3], 3);
  endproperty
  a_mosi_lead: assert property (p_mosi_lead) else $error("master data late");
  property p_miso_lead;
    $rose(pin[2]) && dev_oe[4] |-> $stable(pin[4]);
  endproperty
  a_miso_lead: assert property (p_miso_lead) else $error("slave data late");
  property p_release;
    $rose(pin[5]) |-> ##[1:4] !dev_oe[4];
  endproperty
  a_release: assert property (p_release) else $error("data line held");
  property p_one_clk;
    far_oe[2] |-> !dev_oe[2];
  endproperty
  a_one_clk: assert property (p_one_clk) else $error("clock contention");
endmodule : epm_sva
`default_nettype wire

// *** testbench/test_encoder_spi_pin_function_mux.sv ***
// Bench joining the pin mux to its far end over the shared pins
`default_nettype none
module test_encoder_spi_pin_function_mux;
  timeunit 1ns;
  timeprecision 1ns;
  import epm_pkg::*;
  logic        clock, reset_n, dwr, drd, fwr, frd;
  epm_addr_t   addr;
  epm_data_t   wdata, d_rdata, f_rdata;
  logic [10:0] stim;
  wire  [4:0]  obs;
  int          err_total, check_count;
  epm_if u_epm_if ();
  epm_device u_epm_device (.clock(clock), .reset_n(reset_n), .pins(u_epm_if.dev), .addr(addr),
    .wdata(wdata), .wr_stb(dwr), .rd_stb(drd), .rdata(d_rdata), .qdec_index_input(obs[0]),
    .qdec_home_input(obs[1]), .timer_two_o(stim[0]), .timer_two_oe(stim[1]),
    .timer_two_i(obs[2]), .timer_three_o(stim[2]), .timer_three_oe(stim[3]),
    .timer_three_i(obs[3]), .system_clock_monitor(stim[4]), .prescaler_clock_monitor(stim[5]),
    .pulse_output_zero(stim[6]), .async1_transmit_output(stim[7]),
    .async1_receive_input(obs[4]), .test_clock(stim[8]), .test_shift(stim[9]),
    .test_data(stim[10]));
  epm_far u_epm_far (.clock(clock), .reset_n(reset_n), .pins(u_epm_if.far), .addr(addr),
    .wdata(wdata), .wr_stb(fwr), .rd_stb(frd), .rdata(f_rdata));
  epm_sva u_epm_sva (.clock(clock), .reset_n(reset_n), .dev_oe(u_epm_if.dev_oe),
    .dev_pu(u_epm_if.dev_pu), .far_oe(u_epm_if.far_oe), .pin(u_epm_if.pin),
    .test_out_oe(u_epm_if.test_out_oe));
  task automatic chk(input epm_data_t got, input epm_data_t exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input bit f, input epm_addr_t a, input epm_data_t d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    fwr   <= f;
    dwr   <= !f;
    @(posedge clock);
    fwr <= 1'b0;
    dwr <= 1'b0;
  endtask : wr
  task automatic rd(input bit f, input epm_addr_t a, input epm_data_t e,
                    input epm_data_t m = 16'hFFFF);
    @(posedge clock);
    addr <= a;
    frd  <= f;
    drd  <= !f;
    @(posedge clock);
    frd <= 1'b0;
    drd <= 1'b0;
    #1 chk((f ? f_rdata : d_rdata) & m, e);
  endtask : rd
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : waitc
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Frames take about 130 cycles each; the whole run stays far below this
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {reset_n, dwr, drd, fwr, frd} = 5'h10;
    addr = 4'h0;
    wdata = 16'h0000;
    stim = 11'h000;
    err_total = 0;
    check_count = 0;
    u_epm_if.ext_o = 7'h02;
    u_epm_if.ext_oe = 7'h03;
    // Reset falls after time zero so the asynchronous reset is always seen
    #1 reset_n = 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(1'b0, epm_addr_t'(i), 16'h0000);
    end
    rd(1'b0, 4'hF, 16'h0000);
    chk({14'h0000, obs[1:0]}, 16'h0002);
    // Timer three drives low, system clock monitor held high
    stim <= 11'h018;
    wr(1'b0, 4'h0, 16'h0003);
    wr(1'b0, 4'h1, 16'h0001);
    waitc(3);
    chk({12'h000, obs[3:2], u_epm_if.pin[1:0]}, 16'h0001);
    wr(1'b0, 4'h0, 16'h0002);
    wr(1'b0, 4'h1, 16'h0002);
    wr(1'b0, 4'h7, 16'h0001);
    wr(1'b0, 4'h8, 16'h0003);
    waitc(3);
    rd(1'b0, 4'h9, 16'h0003, 16'h0003);
    wr(1'b0, 4'h7, 16'h0002);
    waitc(3);
    rd(1'b0, 4'h9, 16'h0002, 16'h0003);
    u_epm_if.ext_o <= 7'h00;
    u_epm_if.ext_oe <= 7'h10;
    stim <= 11'h000;
    wr(1'b0, 4'h4, 16'h0001);
    wr(1'b0, 4'h5, 16'h0001);
    waitc(3);
    chk({14'h0000, obs[4], u_epm_if.pin[5]}, 16'h0000);
    wr(1'b0, 4'h4, 16'h0000);
    wr(1'b0, 4'h5, 16'h0000);
    // Select held low by the bench for the far slave
    u_epm_if.ext_oe <= 7'h20;
    // Master first: its clock falling from the pull-up must not shift the preload
    wr(1'b0, 4'hA, 16'h0003);
    wr(1'b1, 4'h0, 16'h0002);
    wr(1'b1, 4'h1, 16'h003C);
    wr(1'b0, 4'hB, 16'h00A5);
    waitc(64);
    rd(1'b0, 4'hD, 16'h0001);
    waitc(70);
    rd(1'b0, 4'hD, 16'h0002);
    rd(1'b0, 4'hC, 16'h003C);
    rd(1'b1, 4'h2, 16'h00A5);
    wr(1'b0, 4'hD, 16'h0002);
    rd(1'b0, 4'hD, 16'h0000);
    u_epm_if.ext_oe <= 7'h00;
    wr(1'b0, 4'hA, 16'h0002);
    wr(1'b0, 4'hB, 16'h005A);
    wr(1'b1, 4'h0, 16'h0003);
    wr(1'b1, 4'h1, 16'h00C3);
    waitc(140);
    rd(1'b0, 4'hC, 16'h00C3);
    rd(1'b1, 4'h2, 16'h005A);
    // Test clock rises with data low; output must wait for the fall
    stim <= 11'h300;
    waitc(4);
    chk({14'h0000, u_epm_if.test_out_oe, u_epm_if.test_out_o}, 16'h0003);
    stim <= 11'h200;
    waitc(4);
    chk({14'h0000, u_epm_if.test_out_oe, u_epm_if.test_out_o}, 16'h0002);
    tally_and_finish();
  end
endmodule : test_encoder_spi_pin_function_mux
`default_nettype wire
